// ===== pwmc_chk.sv
// Checker for the bus handshake, pin enables and interrupt masking.
// Assumes it is bound into pwmc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_regs.vh"
module pwmc_chk (
  input wire logic                i_clk_sys,
  input wire logic                i_reset,
  input wire logic [`PWMC_AW-1:0] i_avs_address,
  input wire logic                i_avs_read,
  input wire logic                i_avs_write,
  input wire logic [31:0]         i_avs_writedata,
  input wire logic [3:0]          i_avs_byteenable,
  input wire logic [31:0]         o_avs_readdata,
  input wire logic                o_avs_waitrequest,
  input wire logic [7:0]          o_port1_oe,
  input wire logic                o_timer0_interrupt,
  input wire logic                o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire logic cw   = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire logic cr   = i_avs_read && !o_avs_waitrequest;
  wire logic dirw = cw && i_avs_address == `PWMC_OFS_P1DIR;
  wire logic rq   = i_avs_read && o_avs_waitrequest;
  AST_WAIT_ONE: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_OE_CAUSE: assert property ($changed(o_port1_oe) |-> $past(dirw) || $past(dirw, 2))
    else $error("pin enables changed without a direction write");
  AST_INT_MASKED: assert property (cw && i_avs_address == `PWMC_OFS_IRQMSK && i_avs_writedata[1]
    |-> ##2 !o_timer0_interrupt)
    else $error("timer 0 interrupt high while masked");
  AST_IRQ_MASKED: assert property (cw && i_avs_address == `PWMC_OFS_EVMASK && i_avs_writedata[1:0] == 2'h0
    |-> ##2 !o_irq)
    else $error("event interrupt high with all events masked");
  AST_STAT_RSV: assert property (cr && i_avs_address == `PWMC_OFS_T0STAT |-> o_avs_readdata[7:5] == 3'h0)
    else $error("reserved status bits read nonzero");
  AST_UNMAPPED: assert property (cr && i_avs_address > `PWMC_OFS_IRQEN |-> o_avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  AST_RDATA_HOLD: assert property ($changed(o_avs_readdata) |-> $past(rq))
    else $error("read data changed without a read");
endmodule
bind pwmc_top pwmc_chk u_pwmc_chk (.i_clk_sys, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_port1_oe,
  .o_timer0_interrupt, .o_irq);
`default_nettype wire

// ===== pwmc_regs.vh
// Register offsets, field positions and reset values of the PWM port,
// interrupt and count-start register bank.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef PWMC_REGS_VH
`define PWMC_REGS_VH

`define PWMC_AW            6
`define PWMC_OFS_P1DATA    6'h00
`define PWMC_OFS_P1DIR     6'h04
`define PWMC_OFS_T0STAT    6'h08
`define PWMC_OFS_IRQREQ    6'h0c
`define PWMC_OFS_IRQMSK    6'h10
`define PWMC_OFS_CSTART    6'h14
`define PWMC_OFS_PERA0     6'h18
`define PWMC_OFS_CNT0      6'h1c
`define PWMC_OFS_CNT1      6'h20
`define PWMC_OFS_EVSTAT    6'h24
`define PWMC_OFS_EVMASK    6'h28
`define PWMC_OFS_IRQEN     6'h2c

`define PWMC_ST_MFA        0
`define PWMC_ST_OVF        4
`define PWMC_ST_W          5
`define PWMC_IRQ_T0        1
`define PWMC_IRQ_FIXED     5
`define PWMC_CS_RUN0       0
`define PWMC_CS_RUN1       1
`define PWMC_CS_W          4
`define PWMC_EV_MFA        0
`define PWMC_EV_OVF        1
`define PWMC_EV_W          2

`define PWMC_RST_P1DATA    8'h00
`define PWMC_RST_P1DIR     8'hff
`define PWMC_RST_IRQREQ    8'h00
`define PWMC_RST_IRQMSK    8'hff
`define PWMC_RST_CSTART    4'h0
`define PWMC_RST_PERA0     16'hffff
`define PWMC_RST_WAIT_ACK  1'b1

`endif

// ===== pwmc_rwz_flag.v
// One status flag cleared by a zero write that follows a read of it set.
// Assumes the bank reports status reads and writes as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module pwmc_rwz_flag (
  input  wire i_clk_sys,
  input  wire i_reset,
  input  wire i_set,
  input  wire i_read,
  input  wire i_write,
  input  wire i_wdata,
  output wire o_flag
);
  reg flag_r;
  reg armed_r;

  // A read arms the clear only if it actually saw the flag set
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      flag_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (i_set)
        flag_r <= 1'b1;
      else if (i_write && !i_wdata && armed_r)
        flag_r <= 1'b0;
      if (i_write)
        armed_r <= 1'b0;
      else if (i_read)
        armed_r <= flag_r;
    end
  end

  assign o_flag = flag_r;
endmodule
`default_nettype wire

// ===== pwmc_stage.sv
// Power stage model on port 1: returns pin levels to the block.
// Assumes undriven pins float, so they show a pattern that flips every cycle.
`timescale 1ns/1ps
`default_nettype none
module pwmc_stage (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  output var  logic [7:0] o_pin
);
  logic [7:0] flt_r = 8'h5a;
  always @(posedge i_clk_sys) flt_r <= ~flt_r;
  always_comb o_pin = (i_out & i_oe) | (flt_r & ~i_oe);
endmodule
`default_nettype wire

// ===== pwmc_top.v
// Register bank around a complementary PWM counter pair: port 1
// direction and data, timer status flags, timer 0 interrupt request
// and mask, count start flags, plus a sticky event interrupt.
// Assumes a single Avalon-MM master with waitrequest and synchronous pins.
// Function
// - Port 1 direction bit 0 drives the pin, 1 makes it an input.
// - Match flag A sets when counter 0 equals period register A0.
// - A flag clears only on a zero write after reading it set.
// - Status: bit 4 overflow, bits 3-0 flags D C B A, 7-5 reserved.
// - Timer 0 request flag bit 1 reads 1 while a request is pending.
// - Mask bit 1 at 0 allows servicing, at 1 blocks it.
// - Count start bit 1 runs counter 1, bit 0 runs counter 0.
// - Counter 0 overflow sets the overflow status flag.
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_regs.vh"
module pwmc_top #(
  parameter CNT_W = 16
) (
  input  wire                 i_clk_sys,
  input  wire                 i_reset,
  input  wire [`PWMC_AW-1:0]  i_avs_address,
  input  wire                 i_avs_read,
  input  wire                 i_avs_write,
  input  wire [31:0]          i_avs_writedata,
  input  wire [3:0]           i_avs_byteenable,
  output wire [31:0]          o_avs_readdata,
  output wire                 o_avs_waitrequest,
  input  wire [7:0]           i_port1_in,
  output wire [7:0]           o_port1_out,
  output wire [7:0]           o_port1_oe,
  input  wire [2:0]           i_match_bcd,
  output wire                 o_timer0_interrupt,
  output wire                 o_irq
);

  // Bus handshake state
  reg                 wait_r;
  reg [31:0]          rdata_r;

  // Software-visible registers
  reg [7:0]           p1_data_r;
  reg [7:0]           p1_dir_r;
  reg [7:0]           p1_oe_r;
  reg [7:0]           irq_req_r;
  reg [7:0]           irq_req_nxt;
  reg [7:0]           irq_msk_r;
  reg [`PWMC_CS_W-1:0] cstart_r;
  reg [CNT_W-1:0]     per_a0_r;
  reg                 irqen_a_r;
  reg [`PWMC_EV_W-1:0] ev_r;
  reg [`PWMC_EV_W-1:0] ev_nxt;
  reg [`PWMC_EV_W-1:0] ev_msk_r;
  reg                 t0_int_r;
  reg                 irq_r;

  wire [`PWMC_ST_W-1:0] st_flags;
  wire [`PWMC_ST_W-1:0] st_set;
  wire [CNT_W-1:0]    cnt0;
  wire [CNT_W-1:0]    cnt1;
  wire                match0;
  wire                ovf0;
  wire                run0;
  wire                run1;

  // Access strobes: read data is taken while waitrequest is high,
  // writes commit on the edge where waitrequest is seen low
  wire rd_take = i_avs_read && wait_r;
  wire wr_go   = i_avs_write && !wait_r;
  wire wr_b0   = wr_go && i_avs_byteenable[0];
  wire wr_b1   = wr_go && i_avs_byteenable[1];

  function sel;
    input [`PWMC_AW-1:0] a;
    input [`PWMC_AW-1:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  wire hit_p1data = sel(i_avs_address, `PWMC_OFS_P1DATA);
  wire hit_p1dir  = sel(i_avs_address, `PWMC_OFS_P1DIR);
  wire hit_t0stat = sel(i_avs_address, `PWMC_OFS_T0STAT);
  wire hit_irqreq = sel(i_avs_address, `PWMC_OFS_IRQREQ);
  wire hit_irqmsk = sel(i_avs_address, `PWMC_OFS_IRQMSK);
  wire hit_cstart = sel(i_avs_address, `PWMC_OFS_CSTART);
  wire hit_pera0  = sel(i_avs_address, `PWMC_OFS_PERA0);
  wire hit_cnt0   = sel(i_avs_address, `PWMC_OFS_CNT0);
  wire hit_cnt1   = sel(i_avs_address, `PWMC_OFS_CNT1);
  wire hit_evstat = sel(i_avs_address, `PWMC_OFS_EVSTAT);
  wire hit_evmask = sel(i_avs_address, `PWMC_OFS_EVMASK);
  wire hit_irqen  = sel(i_avs_address, `PWMC_OFS_IRQEN);

  assign run0 = cstart_r[`PWMC_CS_RUN0];
  assign run1 = cstart_r[`PWMC_CS_RUN1];

  // One wait cycle for every access, so read data is always a flop
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      wait_r <= `PWMC_RST_WAIT_ACK;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (i_avs_read || i_avs_write) begin
      wait_r <= 1'b0;
    end
  end

  // Read mux; input-mode pins read their level, output pins the latch
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_r <= 32'h0000_0000;
      if (hit_p1data)
        rdata_r[7:0] <= (p1_data_r & ~p1_dir_r) | (i_port1_in & p1_dir_r);
      if (hit_p1dir)
        rdata_r[7:0] <= p1_dir_r;
      if (hit_t0stat)
        rdata_r[`PWMC_ST_W-1:0] <= st_flags;
      if (hit_irqreq)
        rdata_r[7:0] <= irq_req_r;
      if (hit_irqmsk)
        rdata_r[7:0] <= irq_msk_r;
      if (hit_cstart)
        rdata_r[`PWMC_CS_W-1:0] <= cstart_r;
      if (hit_pera0)
        rdata_r[CNT_W-1:0] <= per_a0_r;
      if (hit_cnt0)
        rdata_r[CNT_W-1:0] <= cnt0;
      if (hit_cnt1)
        rdata_r[CNT_W-1:0] <= cnt1;
      if (hit_evstat)
        rdata_r[`PWMC_EV_W-1:0] <= ev_r;
      if (hit_evmask)
        rdata_r[`PWMC_EV_W-1:0] <= ev_msk_r;
      if (hit_irqen)
        rdata_r[0] <= irqen_a_r;
    end
  end

  // Port 1 data and direction
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      p1_data_r <= `PWMC_RST_P1DATA;
      p1_dir_r  <= `PWMC_RST_P1DIR;
      p1_oe_r   <= ~`PWMC_RST_P1DIR;
    end else begin
      if (wr_b0 && hit_p1data)
        p1_data_r <= i_avs_writedata[7:0];
      if (wr_b0 && hit_p1dir) begin
        p1_dir_r <= i_avs_writedata[7:0];
        p1_oe_r  <= ~i_avs_writedata[7:0];
      end
    end
  end

  // Status flags A-D and overflow, each with read-then-zero clearing
  assign st_set = {ovf0, i_match_bcd, match0};

  genvar gi;
  generate
    for (gi = 0; gi < `PWMC_ST_W; gi = gi + 1) begin : g_flag
      pwmc_rwz_flag u_flag (
        .i_clk_sys (i_clk_sys),
        .i_reset   (i_reset),
        .i_set     (st_set[gi]),
        .i_read    (rd_take && hit_t0stat),
        .i_write   (wr_b0 && hit_t0stat),
        .i_wdata   (i_avs_writedata[gi]),
        .o_flag    (st_flags[gi])
      );
    end
  endgenerate

  // Interrupt request byte; hardware set wins over a software clear
  always @* begin
    irq_req_nxt = irq_req_r;
    if (wr_b0 && hit_irqreq)
      irq_req_nxt = i_avs_writedata[7:0];
    irq_req_nxt[`PWMC_IRQ_FIXED] = 1'b0;
    if (match0 && irqen_a_r)
      irq_req_nxt[`PWMC_IRQ_T0] = 1'b1;
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      irq_req_r <= `PWMC_RST_IRQREQ;
      irq_msk_r <= `PWMC_RST_IRQMSK;
      irqen_a_r <= 1'b0;
    end else begin
      irq_req_r <= irq_req_nxt;
      if (wr_b0 && hit_irqmsk) begin
        irq_msk_r <= i_avs_writedata[7:0];
        irq_msk_r[`PWMC_IRQ_FIXED] <= 1'b1;
      end
      if (wr_b0 && hit_irqen)
        irqen_a_r <= i_avs_writedata[0];
    end
  end

  // Timer 0 interrupt line follows request gated by mask one cycle later
  always @(posedge i_clk_sys) begin
    if (i_reset)
      t0_int_r <= 1'b0;
    else
      t0_int_r <= irq_req_r[`PWMC_IRQ_T0] && !irq_msk_r[`PWMC_IRQ_T0];
  end

  // Count start flags and period register
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      cstart_r <= `PWMC_RST_CSTART;
      per_a0_r <= `PWMC_RST_PERA0;
    end else begin
      if (wr_b0 && hit_cstart)
        cstart_r <= i_avs_writedata[`PWMC_CS_W-1:0];
      // Period writes while running are accepted; software must avoid them
      if (wr_b0 && hit_pera0)
        per_a0_r[7:0] <= i_avs_writedata[7:0];
      if (wr_b1 && hit_pera0)
        per_a0_r[CNT_W-1:8] <= i_avs_writedata[CNT_W-1:8];
    end
  end

  pwmc_tri_counter #(
    .W (CNT_W)
  ) u_cnt0 (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_run      (run0),
    .i_load     (wr_b0 && wr_b1 && hit_cnt0),
    .i_load_val (i_avs_writedata[CNT_W-1:0]),
    .i_period   (per_a0_r),
    .o_count    (cnt0),
    .o_match    (match0),
    .o_ovf      (ovf0)
  );

  // Counter 1 shares the period; its events raise no flags here
  pwmc_tri_counter #(
    .W (CNT_W)
  ) u_cnt1 (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_run      (run1),
    .i_load     (wr_b0 && wr_b1 && hit_cnt1),
    .i_load_val (i_avs_writedata[CNT_W-1:0]),
    .i_period   (per_a0_r),
    .o_count    (cnt1),
    .o_match    (),
    .o_ovf      ()
  );

  // Sticky event bits, write one to clear, new event beats the clear
  always @* begin
    ev_nxt = ev_r;
    if (wr_b0 && hit_evstat)
      ev_nxt = ev_r & ~i_avs_writedata[`PWMC_EV_W-1:0];
    if (match0)
      ev_nxt[`PWMC_EV_MFA] = 1'b1;
    if (ovf0)
      ev_nxt[`PWMC_EV_OVF] = 1'b1;
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      ev_r     <= {`PWMC_EV_W{1'b0}};
      ev_msk_r <= {`PWMC_EV_W{1'b0}};
      irq_r    <= 1'b0;
    end else begin
      ev_r  <= ev_nxt;
      irq_r <= |(ev_nxt & ev_msk_r);
      if (wr_b0 && hit_evmask)
        ev_msk_r <= i_avs_writedata[`PWMC_EV_W-1:0];
    end
  end

  assign o_avs_readdata     = rdata_r;
  assign o_avs_waitrequest  = wait_r;
  assign o_port1_out        = p1_data_r;
  assign o_port1_oe         = p1_oe_r;
  assign o_timer0_interrupt = t0_int_r;
  assign o_irq              = irq_r;

endmodule
`default_nettype wire

// ===== pwmc_top_tb.sv
// Testbench: register bank driven over Avalon-MM, expected reads queued.
// Assumes pwmc_top, pwmc_stage and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "pwmc_regs.vh"
module pwmc_top_tb;
  logic        clk = 0;
  logic        rst = 1;
  logic [5:0]  adr = 0;
  logic        rd = 0;
  logic        wr = 0;
  logic [31:0] wd = 0;
  logic [2:0]  bcd = 0;
  logic [31:0] rdat;
  logic        wq, t0i, irq;
  logic [7:0]  pout, poe, pin, dat;
  logic [63:0] e;
  logic [63:0] exp_q[$];
  integer      error_cnt = 0, check_count = 0, seed = 32'h6b911538, cyc = 0, i;
  always #10 clk = ~clk;
  pwmc_top u_pwmc_top (.i_clk_sys(clk), .i_reset(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .i_port1_in(pin), .o_port1_out(pout), .o_port1_oe(poe),
    .i_match_bcd(bcd), .o_timer0_interrupt(t0i), .o_irq(irq));
  pwmc_stage u_pwmc_stage (.i_clk_sys(clk), .i_out(pout), .i_oe(poe), .o_pin(pin));
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Request held until waitrequest is sampled low
  task xfer(input logic r, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    rd <= r;
    wr <= !r;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task wreg(input logic [5:0] a, input logic [31:0] d);
    xfer(1'b0, a, d);
  endtask
  task rreg(input logic [5:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({m, x & m});
    xfer(1'b1, a, 32'h0);
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 4000) begin
      error_cnt++;
      wrap_up;
    end
    if (rd && wq === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("readdata", rdat & e[63:32], e[31:0]);
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rreg(`PWMC_OFS_P1DIR, 32'hff, 32'hff);
    rreg(`PWMC_OFS_T0STAT, 32'h0, 32'hff);
    rreg(`PWMC_OFS_IRQREQ, 32'h0, 32'hff);
    rreg(`PWMC_OFS_IRQMSK, 32'hff, 32'hff);
    rreg(`PWMC_OFS_CSTART, 32'h0, 32'hf);
    wreg(6'h30, 32'hffffffff);
    rreg(6'h30, 32'h0, 32'hffffffff);
    chk("oe", {24'h0, poe}, 32'h0);
    $display("test reset done");
    dat = 8'($random(seed));
    wreg(`PWMC_OFS_P1DIR, 32'h81);
    wreg(`PWMC_OFS_P1DATA, {24'h0, dat});
    tick(2);
    chk("oe", {24'h0, poe}, 32'h7e);
    chk("out", {24'h0, pout}, {24'h0, dat});
    rreg(`PWMC_OFS_P1DATA, {24'h0, dat}, 32'h7e);
    $display("test port done");
    wreg(`PWMC_OFS_PERA0, 32'h8);
    wreg(`PWMC_OFS_IRQEN, 32'h1);
    wreg(`PWMC_OFS_EVMASK, 32'h3);
    rreg(`PWMC_OFS_T0STAT, 32'h0, 32'h1);
    wreg(`PWMC_OFS_T0STAT, 32'h0);
    wreg(`PWMC_OFS_IRQREQ, 32'h0);
    wreg(`PWMC_OFS_IRQMSK, 32'hfd);
    wreg(`PWMC_OFS_CSTART, 32'h3);
    for (i = 0; i < 100 && t0i !== 1'b1; i++) @(posedge clk);
    chk("t0int", {31'h0, t0i}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    bcd <= 3'b111;
    @(posedge clk);
    bcd <= 3'b000;
    tick(40);
    wreg(`PWMC_OFS_CSTART, 32'h0);
    rreg(`PWMC_OFS_IRQREQ, 32'h2, 32'h2);
    rreg(`PWMC_OFS_T0STAT, 32'h1f, 32'hff);
    wreg(`PWMC_OFS_T0STAT, 32'hff);
    wreg(`PWMC_OFS_T0STAT, 32'h0);
    rreg(`PWMC_OFS_T0STAT, 32'h1f, 32'hff);
    wreg(`PWMC_OFS_T0STAT, 32'h0);
    rreg(`PWMC_OFS_T0STAT, 32'h0, 32'hff);
    $display("test status done");
    wreg(`PWMC_OFS_IRQMSK, 32'hff);
    tick(2);
    chk("t0int", {31'h0, t0i}, 32'h0);
    wreg(`PWMC_OFS_IRQREQ, 32'h0);
    rreg(`PWMC_OFS_IRQREQ, 32'h0, 32'h2);
    wreg(`PWMC_OFS_IRQREQ, 32'h0);
    rreg(`PWMC_OFS_IRQREQ, 32'h0, 32'h2);
    wreg(`PWMC_OFS_EVMASK, 32'h0);
    tick(2);
    chk("irq", {31'h0, irq}, 32'h0);
    wreg(`PWMC_OFS_EVSTAT, 32'h3);
    wreg(`PWMC_OFS_EVMASK, 32'h3);
    tick(2);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test interrupt done");
    wreg(`PWMC_OFS_CNT0, 32'h5);
    wreg(`PWMC_OFS_CSTART, 32'h2);
    tick(5);
    rreg(`PWMC_OFS_CNT0, 32'h5, 32'hffff);
    rreg(`PWMC_OFS_CSTART, 32'h2, 32'h3);
    wreg(`PWMC_OFS_CSTART, 32'h0);
    $display("test counter done");
    wrap_up;
  end
endmodule
`default_nettype wire

// ===== pwmc_tri_counter.v
// Up/down counter turning at a period value and at zero.
// Assumes i_run steps it once per clock; loads only take effect while stopped.
`timescale 1ns/1ps
`default_nettype none
module pwmc_tri_counter #(
  parameter W = 16
) (
  input  wire         i_clk_sys,
  input  wire         i_reset,
  input  wire         i_run,
  input  wire         i_load,
  input  wire [W-1:0] i_load_val,
  input  wire [W-1:0] i_period,
  output wire [W-1:0] o_count,
  output wire         o_match,
  output wire         o_ovf
);
  reg [W-1:0] cnt_r;
  reg         up_r;

  assign o_match = i_run && (cnt_r == i_period);
  // Reaching zero on the way down, where the count turns back up, is the overflow point
  assign o_ovf   = i_run && !up_r && (cnt_r == {W{1'b0}});
  assign o_count = cnt_r;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      cnt_r <= {W{1'b0}};
      up_r  <= 1'b1;
    end else if (i_run) begin
      if (up_r) begin
        if (cnt_r >= i_period) begin
          up_r  <= 1'b0;
          cnt_r <= cnt_r - 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end else begin
        if (cnt_r == {W{1'b0}}) begin
          up_r  <= 1'b1;
          cnt_r <= cnt_r + 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end else if (i_load) begin
      cnt_r <= i_load_val;
      up_r  <= 1'b1;
    end
  end
endmodule
`default_nettype wire
